//--- verilog/psg_pkg.sv
package psg_pkg;
  localparam int unsigned CLK_HZ        = 40000000;
  localparam int unsigned NPIN          = 10;
  localparam logic [7:0]  ADR_DIR       = 8'h20;
  localparam logic [7:0]  ADR_DAT       = 8'h22;
  localparam logic [7:0]  ADR_INMODE    = 8'h24;
  localparam logic [7:0]  ADR_INTEN     = 8'h26;
  localparam logic [7:0]  ADR_EDGE      = 8'h28;
  localparam logic [7:0]  ADR_INTSTAT   = 8'h2a;
  localparam logic [7:0]  ADR_OUTMODE   = 8'h2c;
  localparam logic [7:0]  ADR_FUNC      = 8'h2e;
  localparam logic [7:0]  ADR_PINOFF    = 8'h30;
  localparam logic [7:0]  ADR_PSTATE    = 8'h31;
  localparam logic [7:0]  ADR_SYSCTL    = 8'h32;
  localparam logic [10:0] EDGE_RST      = 11'h7fe;
  localparam logic [10:0] ZERO_RST      = 11'h000;
  localparam logic [10:0] OD_ONLY_MASK  = 11'h02e;
  localparam int unsigned PST_ON_BIT    = 0;
  localparam int unsigned PST_SHORT_BIT = 1;
  localparam int unsigned PST_MED_BIT   = 2;
  localparam int unsigned PST_MSEL_LSB  = 4;
  localparam int unsigned SHORT_MS      = 100;
  localparam int unsigned MED_BASE_S    = 2;
  localparam int unsigned LONG_S        = 15;
  localparam int unsigned UC_RST_MS     = 4;
  localparam int unsigned MS_CYC        = CLK_HZ / 1000;
  localparam int unsigned SHORT_CYC     = SHORT_MS * MS_CYC;
  localparam int unsigned UC_RST_CYC    = UC_RST_MS * MS_CYC;
  localparam int unsigned SEC_CYC       = CLK_HZ;
  localparam int unsigned LONG_CYC      = LONG_S * SEC_CYC;
  typedef enum logic [1:0] {
    PSG_OFF   = 2'b00,
    PSG_CKON  = 2'b01,
    PSG_ON    = 2'b10
  } psg_pwr_t;
endpackage

//--- verilog/psg_switch_det.sv
`timescale 1ns/10ps
module psg_switch_det #(
  parameter int unsigned SHORT_CYC = psg_pkg::SHORT_CYC,
  parameter int unsigned SEC_CYC   = psg_pkg::SEC_CYC,
  parameter int unsigned LONG_CYC  = psg_pkg::LONG_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       pressed,
  input  wire logic [1:0] med_sel,
  output logic            short_evt,
  output logic            med_evt,
  output logic            long_evt
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        prev;
    logic        long_done;
    logic        s_e;
    logic        m_e;
    logic        l_e;
  } psg_sw_st_t;
  psg_sw_st_t st_r;
  psg_sw_st_t st_nxt;
  logic [31:0] med_cyc;
  always_comb begin
    med_cyc = 32'(SEC_CYC) * (32'(psg_pkg::MED_BASE_S) + {30'h0, med_sel});
    st_nxt = st_r;
    st_nxt.s_e = 1'b0;
    st_nxt.m_e = 1'b0;
    st_nxt.l_e = 1'b0;
    st_nxt.prev = pressed;
    if (pressed) begin
      if (!st_r.long_done) begin
        st_nxt.cnt = st_r.cnt + 32'h1;
      end
      if (!st_r.long_done && st_r.cnt >= 32'(LONG_CYC) - 32'h1) begin
        st_nxt.l_e = 1'b1; // R11
        st_nxt.long_done = 1'b1;
      end
    end else begin
      if (st_r.prev && !st_r.long_done) begin
        if (st_r.cnt >= med_cyc) begin
          st_nxt.m_e = 1'b1; // R10
        end else if (st_r.cnt > 32'(SHORT_CYC)) begin
          st_nxt.s_e = 1'b1; // R9
        end
      end
      st_nxt.cnt = 32'h0;
      st_nxt.long_done = 1'b0;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign short_evt = st_r.s_e;
  assign med_evt   = st_r.m_e;
  assign long_evt  = st_r.l_e;
  long_once_a: assert property (@(posedge sys_clk) disable iff (rst)
    long_evt |=> !long_evt) else $error("long event repeated"); // R11
endmodule

//--- verilog/psg_pin_sync.sv
`timescale 1ns/10ps
module psg_pin_sync #(
  parameter int unsigned W = 11
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic [W-1:0]      dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } psg_sync_st_t;
  psg_sync_st_t st_r;
  psg_sync_st_t st_nxt;
  always_comb begin
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1; // R24
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign dout = st_r.s2;
endmodule

//--- verilog/psg_power_gpio.sv
// Behaviour
// R1 - Reset returns all logic, settles off
// R2 - Off state keeps supplies powered down
// R3 - Button or adapter wakes to on
// R4 - Pending interrupt sets on flag, clockgen power
// R5 - Microcontroller reset released 4ms later
// R6 - Firmware checks external program present flag
// R7 - Firmware clears interrupt then sleeps
// R8 - System reset output open-drain active low
// R9 - Press over 100ms gives short event
// R10 - Release after 2..5s gives medium event
// R11 - Hold over 15s resets, forces off
// R12 - Switch events visible in state register
// R13 - Pin-off bit zero selects general purpose
// R14 - Function bit selects special function
// R15 - Pins 4,6..10 push-pull optional
// R16 - Output follows data, read returns written
// R17 - Level input tracks pin, writes ignored
// R18 - Edge input sets data until cleared
// R19 - Interrupts always on rising edge, falling edge if selected
// R20 - Edge sets status, enable gates request
// R21 - Write one clears status bit
// R22 - Edge select resets to both edges
// R23 - Direction bits 10:1, one is output
// R24 - Inputs pass two-flop synchroniser
// R25 - Request is OR of enabled status
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module psg_power_gpio #(
  parameter int unsigned SHORT_CYC  = psg_pkg::SHORT_CYC,
  parameter int unsigned SEC_CYC    = psg_pkg::SEC_CYC,
  parameter int unsigned LONG_CYC   = psg_pkg::LONG_CYC,
  parameter int unsigned UC_RST_CYC = psg_pkg::UC_RST_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [15:0]      rdata,
  input  wire logic        switch_detect_input,
  input  wire logic        adapter_insert,
  input  wire logic        uc_irq_pending,
  input  wire logic        fw_sys_reset,
  input  wire logic        external_program_present,
  output logic             external_program_flag,
  output logic             clockgen_supply_low,
  output logic             microcontroller_supply,
  output logic             uc_reset,
  output logic             regulators_enable,
  output logic             sys_reset_o,
  output logic             sys_reset_oe_n,
  output logic             switch_event_output,
  input  wire logic [10:1] pin_i,
  output logic [10:1]      pin_o,
  output logic [10:1]      pin_oe_n,
  input  wire logic [10:1] special_out,
  output logic [10:1]      touch_sel,
  output logic             pin_irq
);
  typedef struct packed {
    psg_pkg::psg_pwr_t pwr;
    logic [31:0]       tmr;
    logic [10:0]       dir;
    logic [10:0]       dat;
    logic [10:0]       inmode;
    logic [10:0]       inten;
    logic [10:0]       edge_sel;
    logic [10:0]       stat;
    logic [10:0]       outmode;
    logic [10:0]       func;
    logic [10:0]       pinoff;
    logic              short_f;
    logic              med_f;
    logic [1:0]        med_sel;
    logic              sysrst;
    logic              prev_btn;
    logic [10:1]       prev_pin;
    logic [1:0]        arm;
    logic [15:0]       rdata;
    logic [10:1]       po;
    logic [10:1]       poe_n;
  } psg_st_t;
  psg_st_t st_r;
  psg_st_t st_nxt;
  logic [10:1] pin_s;
  logic        btn_s;
  logic        short_evt;
  logic        med_evt;
  logic        long_evt;
  logic [10:0] rise;
  logic [10:0] fall;
  logic [10:0] edg;
  logic [10:0] wclr;
  psg_pin_sync #(.W(11)) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .din     ({pin_i, switch_detect_input}),
    .dout    ({pin_s, btn_s})
  );
  psg_switch_det #(
    .SHORT_CYC (SHORT_CYC),
    .SEC_CYC   (SEC_CYC),
    .LONG_CYC  (LONG_CYC)
  ) u_sw (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .pressed   (btn_s),
    .med_sel   (st_r.med_sel),
    .short_evt (short_evt),
    .med_evt   (med_evt),
    .long_evt  (long_evt)
  );
  always_comb begin
    rise = {pin_s & ~st_r.prev_pin, 1'b0};
    fall = {~pin_s & st_r.prev_pin, 1'b0};
    // Edges are ignored until the synchroniser and the previous-level copy hold real pin levels
    edg  = (rise | (fall & st_r.edge_sel)) & {11{st_r.arm == 2'h3}}; // R19
    wclr = 11'h0;
    st_nxt = st_r;
    if (st_r.arm != 2'h3) begin
      st_nxt.arm = st_r.arm + 2'h1;
    end
    st_nxt.prev_btn = btn_s;
    st_nxt.prev_pin = pin_s;
    st_nxt.rdata = 16'h0;
    // Register writes
    if (wr) begin
      case (addr)
        psg_pkg::ADR_DIR:     st_nxt.dir = {wdata[10:1], 1'b0}; // R23
        psg_pkg::ADR_INMODE:  st_nxt.inmode = {wdata[10:1], 1'b0};
        psg_pkg::ADR_INTEN:   st_nxt.inten = {wdata[10:1], 1'b0};
        psg_pkg::ADR_EDGE:    st_nxt.edge_sel = {wdata[10:1], 1'b0};
        psg_pkg::ADR_INTSTAT: wclr = {wdata[10:1], 1'b0}; // R21
        psg_pkg::ADR_OUTMODE: st_nxt.outmode = {wdata[10:1], 1'b0};
        psg_pkg::ADR_FUNC:    st_nxt.func = {wdata[10:1], 1'b0};
        psg_pkg::ADR_PINOFF:  st_nxt.pinoff = {wdata[10:1], 1'b0};
        psg_pkg::ADR_SYSCTL:  st_nxt.sysrst = wdata[0];
        psg_pkg::ADR_PSTATE: begin
          st_nxt.med_sel = wdata[psg_pkg::PST_MSEL_LSB +: 2];
          if (wdata[psg_pkg::PST_SHORT_BIT]) begin
            st_nxt.short_f = 1'b0;
          end
          if (wdata[psg_pkg::PST_MED_BIT]) begin
            st_nxt.med_f = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // Data bits per pin mode
    for (int i = 1; i <= 10; i++) begin
      if (st_r.dir[i]) begin
        if (wr && addr == psg_pkg::ADR_DAT) begin
          st_nxt.dat[i] = wdata[i]; // R16
        end
      end else if (!st_r.inmode[i]) begin
        st_nxt.dat[i] = pin_s[i]; // R17
      end else begin
        if (wr && addr == psg_pkg::ADR_DAT && !wdata[i]) begin
          st_nxt.dat[i] = 1'b0;
        end
        if (edg[i]) begin
          st_nxt.dat[i] = 1'b1; // R18
        end
      end
    end
    st_nxt.stat = (st_r.stat & ~wclr) | (edg & ~st_r.dir); // R20
    if (short_evt) begin
      st_nxt.short_f = 1'b1; // R12
    end
    if (med_evt) begin
      st_nxt.med_f = 1'b1; // R12
    end
    // Power sequencing
    st_nxt.tmr = 32'h0;
    case (st_r.pwr)
      psg_pkg::PSG_OFF: begin
        if (short_evt || adapter_insert || uc_irq_pending) begin
          st_nxt.pwr = psg_pkg::PSG_CKON; // R3 R4
        end
      end
      psg_pkg::PSG_CKON: begin
        st_nxt.tmr = st_r.tmr + 32'h1;
        if (st_r.tmr >= 32'(UC_RST_CYC) - 32'h1) begin
          st_nxt.pwr = psg_pkg::PSG_ON; // R5
        end
      end
      psg_pkg::PSG_ON: ;
      default: st_nxt.pwr = psg_pkg::PSG_OFF;
    endcase
    if (long_evt) begin
      st_nxt.pwr = psg_pkg::PSG_OFF; // R11
      st_nxt.sysrst = 1'b0;
    end
    // Read data
    if (rd) begin
      case (addr)
        psg_pkg::ADR_DIR:     st_nxt.rdata = {5'h0, st_r.dir};
        psg_pkg::ADR_DAT:     st_nxt.rdata = {5'h0, st_r.dat};
        psg_pkg::ADR_INMODE:  st_nxt.rdata = {5'h0, st_r.inmode};
        psg_pkg::ADR_INTEN:   st_nxt.rdata = {5'h0, st_r.inten};
        psg_pkg::ADR_EDGE:    st_nxt.rdata = {5'h0, st_r.edge_sel};
        psg_pkg::ADR_INTSTAT: st_nxt.rdata = {5'h0, st_r.stat};
        psg_pkg::ADR_OUTMODE: st_nxt.rdata = {5'h0, st_r.outmode};
        psg_pkg::ADR_FUNC:    st_nxt.rdata = {5'h0, st_r.func};
        psg_pkg::ADR_PINOFF:  st_nxt.rdata = {5'h0, st_r.pinoff};
        psg_pkg::ADR_SYSCTL:  st_nxt.rdata = {15'h0, st_r.sysrst};
        psg_pkg::ADR_PSTATE:  st_nxt.rdata = {10'h0, st_r.med_sel, 1'b0, st_r.med_f,
                                              st_r.short_f, st_r.pwr != psg_pkg::PSG_OFF};
        default:              st_nxt.rdata = 16'h0;
      endcase
    end
    // Pin drivers
    for (int i = 1; i <= 10; i++) begin
      st_nxt.po[i] = 1'b0;
      st_nxt.poe_n[i] = 1'b1;
      if (!st_r.pinoff[i]) begin // R13
        if (st_r.func[i]) begin
          st_nxt.po[i] = 1'b0; // R14
          st_nxt.poe_n[i] = special_out[i];
        end else if (st_r.dir[i]) begin
          if (st_r.outmode[i] && !psg_pkg::OD_ONLY_MASK[i]) begin
            st_nxt.po[i] = st_r.dat[i]; // R15
            st_nxt.poe_n[i] = 1'b0;
          end else begin
            st_nxt.po[i] = 1'b0; // R16
            st_nxt.poe_n[i] = st_r.dat[i];
          end
        end
      end
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin // R1
      st_r <= '0;
      st_r.pwr <= psg_pkg::PSG_OFF;
      st_r.edge_sel <= psg_pkg::EDGE_RST; // R22
      st_r.poe_n <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign rdata = st_r.rdata;
  assign clockgen_supply_low = st_r.pwr != psg_pkg::PSG_OFF; // R4
  assign microcontroller_supply = st_r.pwr != psg_pkg::PSG_OFF; // R5
  assign uc_reset = st_r.pwr != psg_pkg::PSG_ON;
  assign regulators_enable = st_r.pwr == psg_pkg::PSG_ON; // R2
  assign external_program_flag = external_program_present; // R6
  assign sys_reset_o = 1'b0;
  assign sys_reset_oe_n = !(st_r.sysrst && fw_sys_reset) && st_r.pwr != psg_pkg::PSG_OFF; // R8
  assign switch_event_output = st_r.short_f | st_r.med_f;
  assign touch_sel = st_r.pinoff[10:1];
  assign pin_o = st_r.po;
  assign pin_oe_n = st_r.poe_n;
  assign pin_irq = |(st_r.stat & st_r.inten); // R25
  uc_release_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(st_r.pwr == psg_pkg::PSG_CKON) |-> uc_reset [*8]) else $error("early release"); // R5
  stat_set_a: assert property (@(posedge sys_clk) disable iff (rst)
    (edg[1] && !st_r.dir[1]) |=> st_r.stat[1]) else $error("edge lost"); // R20
  stat_clr_a: assert property (@(posedge sys_clk) disable iff (rst)
    (wr && addr == psg_pkg::ADR_INTSTAT && wdata[2] && !edg[2]) |=> !st_r.stat[2])
    else $error("clear failed"); // R21
  level_trk_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!st_r.dir[3] && !st_r.inmode[3]) |=> st_r.dat[3] == $past(pin_s[3]))
    else $error("level not tracked"); // R17
  edge_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!st_r.dir[4] && st_r.inmode[4] && st_r.dat[4] && !(wr && addr == psg_pkg::ADR_DAT))
    |=> st_r.dat[4]) else $error("edge data dropped"); // R18
  irq_or_a: assert property (@(posedge sys_clk) disable iff (rst)
    pin_irq == |(st_r.stat & st_r.inten)) else $error("irq mismatch"); // R25
  od_only_a: assert property (@(posedge sys_clk) disable iff (rst)
    !st_r.pinoff[1] ##1 1'b1 |-> pin_o[1] == 1'b0) else $error("pin1 driven high"); // R15
  long_off_a: assert property (@(posedge sys_clk) disable iff (rst)
    long_evt |=> st_r.pwr == psg_pkg::PSG_OFF) else $error("not off"); // R11
  wake_c: cover property (@(posedge sys_clk) st_r.pwr == psg_pkg::PSG_ON);
  irq_c: cover property (@(posedge sys_clk) pin_irq);
  short_c: cover property (@(posedge sys_clk) short_evt);
endmodule

//--- dv/psg_pin_world.sv
`timescale 1ns/10ps
module psg_pin_world (
  input  wire logic [10:1] pin_o,
  input  wire logic [10:1] pin_oe_n,
  input  wire logic [10:1] ext_lvl,
  input  wire logic [10:1] ext_en,
  output logic [10:1]      pin_lvl
);
  // Device drive wins; a released line takes the external level if driven, else floats up to its pull-up
  always_comb begin
    for (int i = 1; i <= 10; i++) begin
      if (!pin_oe_n[i])
        pin_lvl[i] = pin_o[i];
      else if (ext_en[i])
        pin_lvl[i] = ext_lvl[i];
      else
        pin_lvl[i] = 1'b1;
    end
  end
endmodule

//--- dv/power_state_and_gpio_control_bench.sv
`timescale 1ns/10ps
module power_state_and_gpio_control_bench;
  logic        sys_clk, rst, wr, rd, sw, adapter, uc_irq, fw_rst, ext_prog;
  logic        ext_flag, ck_pwr, uc_pwr, uc_reset, reg_en, sr_oe_n, sw_evt, pin_irq;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [10:1] pin_lvl, pin_o, pin_oe_n, touch_sel, special, ext_lvl, ext_en;
  int          fails;
  int          checks_done;

  psg_power_gpio #(.SHORT_CYC(10), .SEC_CYC(50), .LONG_CYC(500), .UC_RST_CYC(20)) u_dut (
    .sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .switch_detect_input(sw), .adapter_insert(adapter),
    .uc_irq_pending(uc_irq), .fw_sys_reset(fw_rst), .external_program_present(ext_prog),
    .external_program_flag(ext_flag), .clockgen_supply_low(ck_pwr),
    .microcontroller_supply(uc_pwr), .uc_reset(uc_reset), .regulators_enable(reg_en),
    .sys_reset_o(), .sys_reset_oe_n(sr_oe_n), .switch_event_output(sw_evt),
    .pin_i(pin_lvl), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .special_out(special),
    .touch_sel(touch_sel), .pin_irq(pin_irq));

  psg_pin_world u_world (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .ext_lvl(ext_lvl),
    .ext_en(ext_en), .pin_lvl(pin_lvl));

  task automatic stop_test;
    if (fails == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic press(input int n);
    @(posedge sys_clk);
    sw <= 1'b1;
    cyc(n);
    @(posedge sys_clk);
    sw <= 1'b0;
    cyc(8);
  endtask
  task automatic wake(input logic by_adapter);
    @(posedge sys_clk);
    adapter <= by_adapter;
    uc_irq <= !by_adapter;
    cyc(4);
    @(posedge sys_clk);
    adapter <= 1'b0;
    uc_irq <= 1'b0;
    cyc(4);
  endtask
  task automatic drive(input logic [10:1] v);
    @(posedge sys_clk);
    ext_en <= 10'h3ff;
    ext_lvl <= v;
    cyc(8);
  endtask

  task automatic t_reset;
    rchk(psg_pkg::ADR_EDGE, 16'h07fe);
    rchk(psg_pkg::ADR_DIR, 16'h0000);
    rchk(psg_pkg::ADR_INTSTAT, 16'h0000);
    rchk(psg_pkg::ADR_PSTATE, 16'h0000);
    chk({13'h0, ck_pwr, reg_en, uc_reset}, 16'h0001);
    rchk(8'h40, 16'h0000);
  endtask
  task automatic t_outputs;
    wreg(psg_pkg::ADR_DIR, 16'h07fe);
    wreg(psg_pkg::ADR_OUTMODE, 16'h07fe);
    wreg(psg_pkg::ADR_DAT, 16'h0554);
    cyc(2);
    chk({5'h0, pin_lvl, 1'b0}, 16'h0554);
    chk({15'h0, pin_oe_n[2]}, 16'h0001);
    rchk(psg_pkg::ADR_DAT, 16'h0554);
    wreg(psg_pkg::ADR_FUNC, 16'h0002);
    cyc(2);
    chk({15'h0, pin_oe_n[1]}, 16'h0001);
    wreg(psg_pkg::ADR_FUNC, 16'h0000);
    wreg(psg_pkg::ADR_PINOFF, 16'h0006);
    cyc(2);
    chk({5'h0, touch_sel, 1'b0}, 16'h0006);
    wreg(psg_pkg::ADR_PINOFF, 16'h0000);
  endtask
  task automatic t_level;
    wreg(psg_pkg::ADR_DIR, 16'h0000);
    drive(10'h2a5);
    rchk(psg_pkg::ADR_DAT, 16'h054a);
    wreg(psg_pkg::ADR_DAT, 16'h0000);
    rchk(psg_pkg::ADR_DAT, 16'h054a);
  endtask
  task automatic t_edge;
    wreg(psg_pkg::ADR_INMODE, 16'h07fe);
    wreg(psg_pkg::ADR_EDGE, 16'h0000);
    wreg(psg_pkg::ADR_INTEN, 16'h0008);
    drive(10'h000);
    wreg(psg_pkg::ADR_INTSTAT, 16'h07fe);
    wreg(psg_pkg::ADR_DAT, 16'h0000);
    drive(10'h014);
    rchk(psg_pkg::ADR_DAT, 16'h0028);
    rchk(psg_pkg::ADR_INTSTAT, 16'h0028);
    chk({15'h0, pin_irq}, 16'h0001);
    wreg(psg_pkg::ADR_INTSTAT, 16'h0000);
    rchk(psg_pkg::ADR_INTSTAT, 16'h0028);
    wreg(psg_pkg::ADR_INTSTAT, 16'h0008);
    rchk(psg_pkg::ADR_INTSTAT, 16'h0020);
    chk({15'h0, pin_irq}, 16'h0000);
    wreg(psg_pkg::ADR_INTSTAT, 16'h0020);
    drive(10'h000);
    rchk(psg_pkg::ADR_INTSTAT, 16'h0000);
    rchk(psg_pkg::ADR_DAT, 16'h0028);
    wreg(psg_pkg::ADR_EDGE, 16'h07fe);
    drive(10'h004);
    wreg(psg_pkg::ADR_INTSTAT, 16'h0008);
    drive(10'h000);
    rchk(psg_pkg::ADR_INTSTAT, 16'h0008);
    wreg(psg_pkg::ADR_DAT, 16'h0000);
    rchk(psg_pkg::ADR_DAT, 16'h0000);
  endtask
  task automatic t_power;
    int k;
    press(20);
    rchk(psg_pkg::ADR_PSTATE, 16'h0003);
    chk({11'h0, ck_pwr, uc_pwr, sw_evt, uc_reset, reg_en}, 16'h001e);
    for (k = 0; k < 40 && uc_reset !== 1'b0; k++) cyc(1);
    chk({14'h0, uc_reset, reg_en}, 16'h0001);
    if (k == 40)
      stop_test;
    wreg(psg_pkg::ADR_SYSCTL, 16'h0001);
    @(posedge sys_clk);
    fw_rst <= 1'b1;
    ext_prog <= 1'b1;
    cyc(2);
    chk({14'h0, sr_oe_n, ext_flag}, 16'h0001);
    @(posedge sys_clk);
    fw_rst <= 1'b0;
    cyc(2);
    chk({15'h0, sr_oe_n}, 16'h0001);
    wreg(psg_pkg::ADR_PSTATE, 16'h0002);
    press(120);
    rchk(psg_pkg::ADR_PSTATE, 16'h0005);
    wreg(psg_pkg::ADR_PSTATE, 16'h0034);
    press(150);
    rchk(psg_pkg::ADR_PSTATE, 16'h0033);
    wreg(psg_pkg::ADR_PSTATE, 16'h0002);
    press(520);
    chk({13'h0, ck_pwr, reg_en, uc_reset}, 16'h0001);
    rchk(psg_pkg::ADR_PSTATE, 16'h0000);
    wake(1'b1);
    chk({15'h0, ck_pwr}, 16'h0001);
    press(520);
    wake(1'b0);
    rchk(psg_pkg::ADR_PSTATE, 16'h0001);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    {rst, wr, rd} = 3'b100;
    {sw, adapter, uc_irq, fw_rst, ext_prog} = 5'h00;
    addr = 8'h00;
    wdata = 16'h0000;
    special = 10'h3ff;
    ext_lvl = 10'h000;
    ext_en = 10'h000;
    fails = 0;
    checks_done = 0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset;
    t_outputs;
    t_level;
    t_edge;
    t_power;
    stop_test;
  end
endmodule
